// ---- rtl/adc_irq_bias_channel_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_defines.svh"

module adc_irq_bias_channel_regs (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  // register access port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output var  logic [7:0]                    reg_rdata,
  output var  logic                          reg_rvalid,
  // events from the serial port and pll
  input  wire logic                          ser_clock_error,
  input  wire logic                          pll_lock_event,
  // agc config register bit 3, owned elsewhere
  input  wire logic                          agc_config_bit3,
  // interrupt view for the pin logic
  output var  logic                          irq_pending,
  output var  logic                          irq_polarity,
  output var  logic [1:0]                    irq_event_mode,
  // bias generator and converter
  output var  adc_regs_pkg::mic_bias_e       mic_bias_level,
  output var  logic                          mic_bias_code_valid,
  output var  adc_regs_pkg::fullscale_e      fullscale_ref_select,
  output var  logic                          fullscale_code_valid,
  // channel one front end
  output var  logic                          chan_one_input_kind,
  output var  adc_regs_pkg::input_source_e   chan_one_input_source,
  output var  logic                          chan_one_source_valid,
  output var  logic                          chan_one_pdm_selected,
  output var  logic                          chan_one_coupling,
  output var  adc_regs_pkg::impedance_e      chan_one_impedance,
  output var  logic                          chan_one_impedance_valid,
  output var  logic                          chan_one_auto_gain_en,
  output var  logic                          chan_one_auto_gain_run,
  output var  logic [5:0]                    chan_one_gain
);
  import adc_regs_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic wr_irq_cfg;
  logic wr_irq_mask0;
  logic wr_bias_fs;
  logic wr_ch1_input;
  logic wr_ch1_gain;
  logic rd_flags;

  // one write strobe per register; writes elsewhere are dropped
  always_comb begin
    wr_irq_cfg   = 1'b0;
    wr_irq_mask0 = 1'b0;
    wr_bias_fs   = 1'b0;
    wr_ch1_input = 1'b0;
    wr_ch1_gain  = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `OFS_IRQ_CFG) begin
        wr_irq_cfg = 1'b1;
      end else if (reg_addr == `OFS_IRQ_MASK0) begin
        wr_irq_mask0 = 1'b1;
      end else if (reg_addr == `OFS_BIAS_FS_CFG) begin
        wr_bias_fs = 1'b1;
      end else if (reg_addr == `OFS_CH1_INPUT_CFG) begin
        wr_ch1_input = 1'b1;
      end else if (reg_addr == `OFS_CH1_GAIN_CFG) begin
        wr_ch1_gain = 1'b1;
      end
    end
  end

  // a read of the latched flags clears them after capture
  assign rd_flags = reg_rd && (reg_addr == `OFS_LATCHED_FLAGS0);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg_byte_t irq_cfg_q;
  reg_byte_t irq_mask0_q;
  reg_byte_t bias_fs_q;
  reg_byte_t ch1_input_q;
  reg_byte_t ch1_gain_q;

  cfg_field_reg #(
    .RESET_VAL (`RST_IRQ_CFG),
    .WMASK     (`WMASK_IRQ_CFG)
  ) u_irq_cfg (
    .clock (clock),
    .rst_n (rst_n),
    .wr_en (wr_irq_cfg),
    .wdata (reg_wdata),
    .q     (irq_cfg_q)
  );

  // mask resets to all ones, so both events start out masked
  cfg_field_reg #(
    .RESET_VAL (`RST_IRQ_MASK0),
    .WMASK     (8'hff)
  ) u_irq_mask0 (
    .clock (clock),
    .rst_n (rst_n),
    .wr_en (wr_irq_mask0),
    .wdata (reg_wdata),
    .q     (irq_mask0_q)
  );

  cfg_field_reg #(
    .RESET_VAL (`RST_BIAS_FS_CFG),
    .WMASK     (`WMASK_BIAS_FS_CFG)
  ) u_bias_fs (
    .clock (clock),
    .rst_n (rst_n),
    .wr_en (wr_bias_fs),
    .wdata (reg_wdata),
    .q     (bias_fs_q)
  );

  cfg_field_reg #(
    .RESET_VAL (`RST_CH1_INPUT_CFG),
    .WMASK     (`WMASK_CH1_INPUT_CFG)
  ) u_ch1_input (
    .clock (clock),
    .rst_n (rst_n),
    .wr_en (wr_ch1_input),
    .wdata (reg_wdata),
    .q     (ch1_input_q)
  );

  cfg_field_reg #(
    .RESET_VAL (`RST_CH1_GAIN_CFG),
    .WMASK     (`WMASK_CH1_GAIN_CFG)
  ) u_ch1_gain (
    .clock (clock),
    .rst_n (rst_n),
    .wr_en (wr_ch1_gain),
    .wdata (reg_wdata),
    .q     (ch1_gain_q)
  );

  // ----------------------------------------------------------------
  // latched interrupt flags
  // ----------------------------------------------------------------
  logic flag_ser_clk_err;
  logic flag_pll_lock;

  irq_flag_bit u_flag_ser (
    .clock       (clock),
    .rst_n       (rst_n),
    .event_pulse (ser_clock_error),
    .clear       (rd_flags),
    .flag        (flag_ser_clk_err)
  );

  irq_flag_bit u_flag_pll (
    .clock       (clock),
    .rst_n       (rst_n),
    .event_pulse (pll_lock_event),
    .clear       (rd_flags),
    .flag        (flag_pll_lock)
  );

  reg_byte_t flags_raw;
  reg_byte_t flags_view;

  // flags sit in bits 7 and 6, the rest read zero
  always_comb begin
    flags_raw = 8'h00;
    flags_raw[`BIT_FLAG_SER_CLK_ERR] = flag_ser_clk_err;
    flags_raw[`BIT_FLAG_PLL_LOCK]    = flag_pll_lock;
  end

  // in masked-readback mode a masked flag reads zero but is still cleared by the read
  always_comb begin
    if (irq_cfg_q[`BIT_LATCH_READBACK]) begin
      flags_view = flags_raw & ~irq_mask0_q;
    end else begin
      flags_view = flags_raw;
    end
  end

  // pending level for the pin logic counts only unmasked flags
  assign irq_pending    = |(flags_raw & ~irq_mask0_q);
  assign irq_polarity   = irq_cfg_q[`BIT_IRQ_POLARITY];
  assign irq_event_mode = irq_cfg_q[`MSB_IRQ_EVENT:`LSB_IRQ_EVENT];

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  reg_byte_t nxt_rdata;

  // unmapped offsets answer zero
  always_comb begin
    if (reg_addr == `OFS_IRQ_CFG) begin
      nxt_rdata = irq_cfg_q;
    end else if (reg_addr == `OFS_IRQ_MASK0) begin
      nxt_rdata = irq_mask0_q;
    end else if (reg_addr == `OFS_LATCHED_FLAGS0) begin
      nxt_rdata = flags_view;
    end else if (reg_addr == `OFS_BIAS_FS_CFG) begin
      nxt_rdata = bias_fs_q;
    end else if (reg_addr == `OFS_CH1_INPUT_CFG) begin
      nxt_rdata = ch1_input_q;
    end else if (reg_addr == `OFS_CH1_GAIN_CFG) begin
      nxt_rdata = ch1_gain_q;
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  logic [7:0] rdata_ff;
  logic       rvalid_ff;

  // read data held until the next read, so a slow host can sample late
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // ----------------------------------------------------------------
  // bias and full-scale decode
  // ----------------------------------------------------------------
  logic [2:0] bias_code;
  logic [1:0] fs_code;

  assign bias_code = bias_fs_q[`MSB_MIC_BIAS:`LSB_MIC_BIAS];
  assign fs_code   = bias_fs_q[`MSB_FULLSCALE:`LSB_FULLSCALE];

  // reserved bias codes fall back to vref so the mic never sees a stray level
  always_comb begin
    mic_bias_code_valid = 1'b1;
    case (bias_code)
      BIAS_VREF:        mic_bias_level = BIAS_VREF;
      BIAS_VREF_SCALED: mic_bias_level = BIAS_VREF_SCALED;
      BIAS_AVDD:        mic_bias_level = BIAS_AVDD;
      default: begin
        mic_bias_level      = BIAS_VREF;
        mic_bias_code_valid = 1'b0;
      end
    endcase
  end

  // reserved full-scale code falls back to the lowest reference
  always_comb begin
    fullscale_code_valid = 1'b1;
    case (fs_code)
      FS_2V75:  fullscale_ref_select = FS_2V75;
      FS_2V50:  fullscale_ref_select = FS_2V50;
      FS_1V375: fullscale_ref_select = FS_1V375;
      default: begin
        fullscale_ref_select = FS_1V375;
        fullscale_code_valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // channel one decode
  // ----------------------------------------------------------------
  logic [1:0] src_code;
  logic [1:0] imp_code;

  assign src_code = ch1_input_q[`MSB_INPUT_SOURCE:`LSB_INPUT_SOURCE];
  assign imp_code = ch1_input_q[`MSB_IMPEDANCE:`LSB_IMPEDANCE];

  assign chan_one_input_kind = ch1_input_q[`BIT_INPUT_KIND];

  // reserved source falls back to differential; pin setup is software's job
  always_comb begin
    chan_one_source_valid = 1'b1;
    case (src_code)
      SRC_ANALOG_DIFF: chan_one_input_source = SRC_ANALOG_DIFF;
      SRC_ANALOG_SE:   chan_one_input_source = SRC_ANALOG_SE;
      SRC_PDM:         chan_one_input_source = SRC_PDM;
      default: begin
        chan_one_input_source = SRC_ANALOG_DIFF;
        chan_one_source_valid = 1'b0;
      end
    endcase
  end

  assign chan_one_pdm_selected = (chan_one_input_source == SRC_PDM);

  // coupling forced to ac for pdm, where the analog path is idle
  assign chan_one_coupling = ch1_input_q[`BIT_COUPLING] & ~chan_one_pdm_selected;

  always_comb begin
    chan_one_impedance_valid = 1'b1;
    case (imp_code)
      IMP_2K5: chan_one_impedance = IMP_2K5;
      IMP_10K: chan_one_impedance = IMP_10K;
      IMP_20K: chan_one_impedance = IMP_20K;
      default: begin
        chan_one_impedance       = IMP_2K5;
        chan_one_impedance_valid = 1'b0;
      end
    endcase
  end

  // agc runs only when enabled here and allowed by the agc config bit
  assign chan_one_auto_gain_en  = ch1_input_q[`BIT_AUTO_GAIN_EN];
  assign chan_one_auto_gain_run = chan_one_auto_gain_en & agc_config_bit3;

  assign chan_one_gain = ch1_gain_q[`MSB_CH1_GAIN:`LSB_CH1_GAIN];

endmodule

`default_nettype wire

// ---- rtl/adc_regs_defines.svh ----
`ifndef ADC_REGS_DEFINES_SVH
`define ADC_REGS_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_IRQ_CFG          8'h32
`define OFS_IRQ_MASK0        8'h33
`define OFS_LATCHED_FLAGS0   8'h36
`define OFS_BIAS_FS_CFG      8'h3b
`define OFS_CH1_INPUT_CFG    8'h3c
`define OFS_CH1_GAIN_CFG     8'h3d

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_IRQ_CFG          8'h00
`define RST_IRQ_MASK0        8'hff
`define RST_BIAS_FS_CFG      8'h00
`define RST_CH1_INPUT_CFG    8'h00
`define RST_CH1_GAIN_CFG     8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_FLAG_SER_CLK_ERR 7
`define BIT_FLAG_PLL_LOCK    6
`define BIT_IRQ_POLARITY     7
`define MSB_IRQ_EVENT        6
`define LSB_IRQ_EVENT        5
`define BIT_LATCH_READBACK   2
`define MSB_MIC_BIAS         6
`define LSB_MIC_BIAS         4
`define MSB_FULLSCALE        1
`define LSB_FULLSCALE        0
`define BIT_INPUT_KIND       7
`define MSB_INPUT_SOURCE     6
`define LSB_INPUT_SOURCE     5
`define BIT_COUPLING         4
`define MSB_IMPEDANCE        3
`define LSB_IMPEDANCE        2
`define BIT_AUTO_GAIN_EN     0
`define MSB_CH1_GAIN         7
`define LSB_CH1_GAIN         2

// ----------------------------------------------------------------
// writable-bit masks (reserved positions read zero)
// ----------------------------------------------------------------
`define WMASK_IRQ_CFG        8'he4
`define WMASK_BIAS_FS_CFG    8'h73
`define WMASK_CH1_INPUT_CFG  8'hfd
`define WMASK_CH1_GAIN_CFG   8'hfc

`endif

// ---- rtl/adc_regs_pkg.sv ----
`default_nettype none

package adc_regs_pkg;

  // microphone bias level codes
  typedef enum logic [2:0] {
    BIAS_VREF        = 3'h0,
    BIAS_VREF_SCALED = 3'h1,
    BIAS_AVDD        = 3'h6
  } mic_bias_e;

  // converter full-scale reference codes
  typedef enum logic [1:0] {
    FS_2V75  = 2'h0,
    FS_2V50  = 2'h1,
    FS_1V375 = 2'h2
  } fullscale_e;

  // channel input source codes
  typedef enum logic [1:0] {
    SRC_ANALOG_DIFF = 2'h0,
    SRC_ANALOG_SE   = 2'h1,
    SRC_PDM         = 2'h2
  } input_source_e;

  // input impedance codes
  typedef enum logic [1:0] {
    IMP_2K5 = 2'h0,
    IMP_10K = 2'h1,
    IMP_20K = 2'h2
  } impedance_e;

  typedef logic [7:0] reg_byte_t;

endpackage

`default_nettype wire

// ---- rtl/irq_flag_bit.sv ----
`timescale 1ns/1ps
`default_nettype none

// sticky event flag, cleared by a read; an event in the clearing cycle wins
module irq_flag_bit (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic event_pulse,
  input  wire logic clear,
  output var  logic flag
);

  logic flag_ff;

  // set has priority so an event coincident with the read is kept
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else if (event_pulse) begin
      flag_ff <= 1'b1;
    end else if (clear) begin
      flag_ff <= 1'b0;
    end
  end

  assign flag = flag_ff;

endmodule

`default_nettype wire

// ---- rtl/cfg_field_reg.sv ----
`timescale 1ns/1ps
`default_nettype none

// byte-wide configuration register; reserved bits are never stored
module cfg_field_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK     = 8'hff
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output var  logic [7:0] q
);

  logic [7:0] value_ff;

  // masking on write keeps reserved bits at zero for readback
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      value_ff <= RESET_VAL & WMASK;
    end else if (wr_en) begin
      value_ff <= wdata & WMASK;
    end
  end

  assign q = value_ff;

endmodule

`default_nettype wire

// ---- dv/adc_regs_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

// --------
// checker
// --------
module adc_regs_sva (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  input  wire logic       ser_clock_error,
  input  wire logic       pll_lock_event,
  input  wire logic       agc_config_bit3,
  input  wire logic       irq_pending,
  input  wire logic       mic_bias_code_valid,
  input  wire logic       fullscale_code_valid,
  input  wire logic       chan_one_pdm_selected,
  input  wire logic       chan_one_coupling,
  input  wire logic       chan_one_auto_gain_en,
  input  wire logic       chan_one_auto_gain_run
);
  logic [7:0] mask_ff;
  logic       sel_ff;
  logic [7:0] wdata_ff;
  logic       rd_flags;

  assign rd_flags = reg_rd && reg_addr == 8'h36;

  // shadow of mask and readback select, so flag reads can be predicted
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask_ff <= 8'hff;
      sel_ff  <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h33) mask_ff <= reg_wdata;
      if (reg_addr == 8'h32) sel_ff <= reg_wdata[2];
    end
  end

  // last write data, since $past only takes a whole signal
  always_ff @(posedge clock) begin
    wdata_ff <= reg_wdata;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_RVALID_PULSE: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered by rvalid");
  AST_RVALID_ONLY: assert property (!reg_rd |=> !reg_rvalid)
    else $error("rvalid without a read");
  AST_SER_LATCH: assert property (
    ser_clock_error ##1 rd_flags && !(sel_ff && mask_ff[7]) |=> reg_rdata[7])
    else $error("clock error flag not latched");
  AST_PLL_LATCH: assert property (
    pll_lock_event ##1 rd_flags && !(sel_ff && mask_ff[6]) |=> reg_rdata[6])
    else $error("lock flag not latched");
  AST_SELF_CLEAR: assert property (
    rd_flags && !ser_clock_error && !pll_lock_event ##1 rd_flags |=> reg_rdata == 8'h00)
    else $error("flags not cleared by read");
  AST_RSVD_FLAGS: assert property (rd_flags |=> reg_rdata[5:0] == 6'h00)
    else $error("reserved flag bits not zero");
  AST_MASKED_READ: assert property (
    rd_flags && sel_ff && mask_ff[7] |=> !reg_rdata[7])
    else $error("masked flag visible in readback");
  AST_MASK_GATES_IRQ: assert property (mask_ff[7] && mask_ff[6] |-> !irq_pending)
    else $error("pending while all masked");
  AST_BIAS_CODE: assert property (
    reg_wr && reg_addr == 8'h3b |=>
      mic_bias_code_valid == (wdata_ff[6:4] inside {3'h0, 3'h1, 3'h6}))
    else $error("bias code validity wrong");
  AST_FS_CODE: assert property (
    reg_wr && reg_addr == 8'h3b |=> fullscale_code_valid == (wdata_ff[1:0] != 2'h3))
    else $error("full-scale code validity wrong");
  // coupling is predicted from the written byte, not from the decoded source
  AST_PDM_COUPLING: assert property (
    reg_wr && reg_addr == 8'h3c |=>
      chan_one_pdm_selected == (wdata_ff[6:5] == 2'h2) &&
      chan_one_coupling == (wdata_ff[4] && wdata_ff[6:5] != 2'h2))
    else $error("coupling wrong for the selected source");
  AST_AGC_GATE: assert property (
    reg_wr && reg_addr == 8'h3c |=>
      chan_one_auto_gain_en == wdata_ff[0] &&
      chan_one_auto_gain_run == (wdata_ff[0] && agc_config_bit3))
    else $error("auto gain enable or run wrong");

  COV_FLAG_READ: cover property (rd_flags ##1 reg_rdata[7]);
  COV_PDM: cover property (chan_one_pdm_selected);
  COV_IRQ: cover property (irq_pending);
endmodule

bind adc_irq_bias_channel_regs adc_regs_sva u_adc_regs_sva (
  .clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
  .ser_clock_error, .pll_lock_event, .agc_config_bit3, .irq_pending, .mic_bias_code_valid,
  .fullscale_code_valid, .chan_one_pdm_selected, .chan_one_coupling,
  .chan_one_auto_gain_en, .chan_one_auto_gain_run
);

`default_nettype wire

// ---- dv/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// -----------
// host model
// -----------
module host_model (
  input  wire logic       clock,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // one access, entered just after an edge; strobes stay up for a
  // following access so no signal is assigned twice in one step
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = !w;
    @(posedge clock);
    #1;
    q = reg_rdata;
    v = reg_rvalid;
  endtask

  // released bus shows inverted values, not the last ones
  task automatic idle();
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
    @(posedge clock);
    #1;
  endtask
endmodule

`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------
// testbench
// ----------
module testbench;
  import adc_regs_pkg::*;
  logic          clock, rst_n, ser_clock_error, pll_lock_event, agc_config_bit3;
  logic [7:0]    reg_addr, reg_wdata, reg_rdata;
  logic          reg_wr, reg_rd, reg_rvalid, irq_pending, irq_polarity;
  logic [1:0]    irq_event_mode;
  logic [5:0]    chan_one_gain;
  mic_bias_e     mic_bias_level;
  fullscale_e    fullscale_ref_select;
  input_source_e chan_one_input_source;
  impedance_e    chan_one_impedance;
  logic          mic_bias_code_valid, fullscale_code_valid, chan_one_input_kind;
  logic          chan_one_source_valid, chan_one_pdm_selected, chan_one_coupling;
  logic          chan_one_impedance_valid, chan_one_auto_gain_en, chan_one_auto_gain_run;
  int            miscompares = 0;
  int            n_checks = 0;

  host_model u_host_model (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid);
  adc_irq_bias_channel_regs u_adc_irq_bias_channel_regs (.clock, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .ser_clock_error,
    .pll_lock_event, .agc_config_bit3, .irq_pending, .irq_polarity, .irq_event_mode,
    .mic_bias_level, .mic_bias_code_valid, .fullscale_ref_select, .fullscale_code_valid,
    .chan_one_input_kind, .chan_one_input_source, .chan_one_source_valid,
    .chan_one_pdm_selected, .chan_one_coupling, .chan_one_impedance,
    .chan_one_impedance_valid, .chan_one_auto_gain_en, .chan_one_auto_gain_run,
    .chan_one_gain);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic v;
    u_host_model.access(1'b0, a, 8'h00, q, v);
    chk("rvalid", 32'h1, {31'h0, v});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    u_host_model.access(1'b1, a, d, q, v);
  endtask

  task automatic pulse(input logic a, input logic p);
    ser_clock_error = a;
    pll_lock_event  = p;
    @(posedge clock);
    #1;
    ser_clock_error = 1'b0;
    pll_lock_event  = 1'b0;
  endtask

  // writable bits per register; anything else reads zero
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h32: return 8'he4;
      8'h33: return 8'hff;
      8'h3b: return 8'h73;
      8'h3c: return 8'hfd;
      8'h3d: return 8'hfc;
      default: return 8'h00;
    endcase
  endfunction

  task automatic reset_test();
    logic [7:0] q;
    for (int i = 0; i < 7; i++) begin
      logic [7:0] a;
      a = (i == 6) ? 8'h50 : ((i < 2) ? 8'h32 + 8'(i) : 8'h36 + 8'(i == 2 ? 0 : i + 2));
      rd(a, q);
      chk("reset", (a == 8'h33) ? 32'hff : 32'h0, {24'h0, q});
    end
    wr(8'h32, 8'hff);
    wr(8'h36, 8'hff);
    rd(8'h32, q);
    chk("irqcfg", 32'he4, {24'h0, q});
    chk("irqpins", 32'h7, {29'h0, irq_polarity, irq_event_mode});
    rd(8'h36, q);
    chk("flagwr", 32'h0, {24'h0, q});
    wr(8'h32, 8'h00);
    $display("test reset done");
  endtask

  task automatic cfg_test();
    logic [7:0]  d, q;
    logic [1:0]  s, m;
    logic [31:0] e, g;
    for (int i = 0; i < 40; i++) begin
      // first eight walk every bias, full-scale, source and impedance code, the rest are random
      d = (i < 8) ? {1'b0, i[2:0], i[1:0], i[1:0]} : 8'($urandom);
      agc_config_bit3 = 1'($urandom);
      // the host owns the supply check and the pin setup that go with these codes
      wr(8'h3b, d);
      wr(8'h3c, d);
      wr(8'h3d, d);
      u_host_model.idle();
      s = d[6:5];
      m = d[3:2];
      e = {28'h0, (d[6:4] inside {3'h0, 3'h1, 3'h6}),
           ((d[6:4] inside {3'h0, 3'h1, 3'h6}) ? d[6:4] : 3'h0)};
      chk("bias", e, {28'h0, mic_bias_code_valid, mic_bias_level});
      e = {29'h0, (d[1:0] != 2'h3), ((d[1:0] == 2'h3) ? 2'h2 : d[1:0])};
      chk("fscale", e, {29'h0, fullscale_code_valid, fullscale_ref_select});
      e = {21'h0, d[7], ((s == 2'h3) ? 2'h0 : s), (s != 2'h3), (s == 2'h2),
           (d[4] && s != 2'h2), ((m == 2'h3) ? 2'h0 : m), (m != 2'h3), d[0],
           (d[0] && agc_config_bit3)};
      g = {21'h0, chan_one_input_kind, chan_one_input_source, chan_one_source_valid,
           chan_one_pdm_selected, chan_one_coupling, chan_one_impedance,
           chan_one_impedance_valid, chan_one_auto_gain_en, chan_one_auto_gain_run};
      chk("chan", e, g);
      chk("gain", {26'h0, d[7:2]}, {26'h0, chan_one_gain});
      for (int k = 0; k < 3; k++) begin
        rd(8'h3b + 8'(k), q);
        chk("readback", {24'h0, d & wmask(8'h3b + 8'(k))}, {24'h0, q});
      end
    end
    $display("test config done");
  endtask

  task automatic irq_test();
    logic [7:0] q;
    wr(8'h33, 8'h3f);
    u_host_model.idle();
    pulse(1'b1, 1'b0);
    chk("pending", 32'h1, {31'h0, irq_pending});
    rd(8'h36, q);
    chk("serflag", 32'h80, {24'h0, q});
    rd(8'h36, q);
    chk("cleared", 32'h0, {24'h0, q});
    u_host_model.idle();
    pulse(1'b0, 1'b1);
    rd(8'h36, q);
    chk("pllflag", 32'h40, {24'h0, q});
    ser_clock_error = 1'b1;
    rd(8'h36, q);
    ser_clock_error = 1'b0;
    chk("racerd", 32'h0, {24'h0, q});
    rd(8'h36, q);
    chk("racewin", 32'h80, {24'h0, q});
    wr(8'h33, 8'hff);
    u_host_model.idle();
    pulse(1'b1, 1'b1);
    chk("masked", 32'h0, {31'h0, irq_pending});
    rd(8'h36, q);
    chk("alllatch", 32'hc0, {24'h0, q});
    wr(8'h32, 8'h04);
    wr(8'h33, 8'hbf);
    u_host_model.idle();
    pulse(1'b1, 1'b1);
    chk("halfmask", 32'h1, {31'h0, irq_pending});
    rd(8'h36, q);
    chk("unmaskrd", 32'h40, {24'h0, q});
    rd(8'h36, q);
    chk("maskclr", 32'h0, {24'h0, q});
    $display("test irq done");
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // the tests need well under 1000 cycles, so this only trips on a hang
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    stop_test();
  end

  initial begin
    void'($urandom(32'hc72c));
    rst_n           = 1'b0;
    ser_clock_error = 1'b0;
    pll_lock_event  = 1'b0;
    agc_config_bit3 = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    reset_test();
    cfg_test();
    irq_test();
    stop_test();
  end
endmodule

`default_nettype wire
